// [core/xchg_swap_digit.sv]
// Word device store with block exchange, byte swap and digit move operations
`timescale 1ns/1ns
module xchg_swap_digit #(
  parameter int DEPTH  = xchg_swap_pkg::DEPTH_DEFAULT,
  parameter int ADDR_W = $clog2(DEPTH)
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              start,
  input  wire logic [1:0]        op,
  input  wire logic              wide_form,
  input  wire logic              counter_operand,
  input  wire logic              number_format_flag,
  input  wire logic [15:0]       first_source_start,
  input  wire logic [15:0]       second_source_start,
  input  wire logic [15:0]       length,
  input  wire logic [15:0]       source_start_digit,
  input  wire logic [15:0]       digit_count,
  input  wire logic [15:0]       dest_start_digit,
  input  wire logic              clear_error,
  input  wire logic              load_en,
  input  wire logic [ADDR_W-1:0] load_addr,
  input  wire logic [15:0]       load_data,
  input  wire logic [ADDR_W-1:0] read_addr,
  output logic      [15:0]       read_data,
  output logic                   busy,
  output logic                   done,
  output logic                   operation_error_flag,
  output logic      [15:0]       error_code_register
);

  xchg_swap_pkg::state_e state_r, state_nxt;
  logic [15:0]       mem_r [DEPTH];
  logic [15:0]       mem_nxt [DEPTH];
  logic [ADDR_W-1:0] pa_r, pa_nxt, pb_r, pb_nxt;
  logic [15:0]       left_r, left_nxt;
  logic [15:0]       read_data_r, read_data_nxt;
  logic              done_r, done_nxt;
  logic              err_r, err_nxt;
  logic [15:0]       code_r, code_nxt;
  logic              busy_r, busy_nxt;
  logic              take;
  logic              go_xchg;
  logic              bad_op;
  logic [15:0]       bad_code;
  logic [ADDR_W-1:0] hi_addr;

  // Both swap forms share it
  function automatic logic [15:0] swap_bytes(input logic [15:0] w);
    return {w[7:0], w[15:8]};
  endfunction

  // True when a block of len words from base runs past the last device
  function automatic logic past_end(input logic [15:0] base, input logic [15:0] len);
    logic [16:0] last;
    last = {1'b0, base} + {1'b0, len} - 17'h00001;
    return last >= 17'(DEPTH);
  endfunction

  // Binary value to four decimal digits, one per nibble
  function automatic logic [15:0] to_bcd(input logic [15:0] v);
    logic [15:0] r;
    r[3:0]   = 4'(v % 16'h000A);
    r[7:4]   = 4'((v / 16'h000A) % 16'h000A);
    r[11:8]  = 4'((v / 16'h0064) % 16'h000A);
    r[15:12] = 4'((v / 16'h03E8) % 16'h000A);
    return r;
  endfunction

  function automatic logic [15:0] from_bcd(input logic [15:0] d);
    logic [15:0] r;
    r = 16'(d[15:12] * 16'h03E8) + 16'(d[11:8] * 16'h0064)
      + 16'(d[7:4] * 16'h000A) + 16'(d[3:0]);
    return r;
  endfunction

  // Nibble move, highest digit first; untouched nibbles keep dst
  function automatic logic [15:0] move_digits(input logic [15:0] src,
                                              input logic [15:0] dst,
                                              input logic [2:0]  m1,
                                              input logic [2:0]  cnt,
                                              input logic [2:0]  dn);
    logic [15:0] r;
    int          s;
    int          d;
    r = dst;
    for (int i = 0; i < 4; i++) begin
      s = int'(m1) - 1 - i;
      d = int'(dn) - 1 - i;
      if (i < int'(cnt) && s >= 0 && d >= 0) begin
        r[d*4 +: 4] = src[s*4 +: 4];
      end
    end
    return r;
  endfunction

  logic [15:0] src_w, dst_w, bin_res, dec_res;
  logic [2:0]  m1_s, cnt_s, dn_s;
  logic        digit_ops_bad;

  always_comb begin
    src_w   = mem_r[first_source_start[ADDR_W-1:0]];
    dst_w   = mem_r[second_source_start[ADDR_W-1:0]];
    m1_s    = source_start_digit[2:0];
    cnt_s   = digit_count[2:0];
    dn_s    = dest_start_digit[2:0];
    // Word operands, so the upper bits must be zero too
    digit_ops_bad = (source_start_digit == 16'h0000)
      || (source_start_digit > 16'(xchg_swap_pkg::DIGITS_PER_WORD))
      || (digit_count == 16'h0000) || (digit_count > source_start_digit)
      || (dest_start_digit < digit_count)
      || (dest_start_digit > 16'(xchg_swap_pkg::DIGITS_PER_WORD));
    bin_res = move_digits(src_w, dst_w, m1_s, cnt_s, dn_s);
    dec_res = from_bcd(move_digits(to_bcd(src_w), to_bcd(dst_w), m1_s, cnt_s, dn_s));
  end

  // Verdict on a request; checks run in a fixed order so only one code wins
  always_comb begin
    take     = start && (state_r == xchg_swap_pkg::ST_IDLE);
    hi_addr  = ADDR_W'(first_source_start + 16'h0001);
    go_xchg  = 1'b0;
    bad_op   = 1'b0;
    bad_code = xchg_swap_pkg::ERR_NONE;
    unique case (op)
      xchg_swap_pkg::OP_BLOCK_XCHG: begin
        if (length == 16'h0000 || length > xchg_swap_pkg::MAX_XCHG_LEN) begin
          bad_op   = 1'b1;
          bad_code = xchg_swap_pkg::ERR_OPERAND;
        end else if (past_end(first_source_start, length)
                     || past_end(second_source_start, length)) begin
          bad_op   = 1'b1;
          bad_code = xchg_swap_pkg::ERR_RANGE;
        end else begin
          go_xchg  = 1'b1;
        end
      end
      xchg_swap_pkg::OP_BYTE_SWAP: begin
        // A counter needs both words, so the narrow form refuses it
        if (counter_operand && !wide_form) begin
          bad_op   = 1'b1;
          bad_code = xchg_swap_pkg::ERR_RANGE;
        end else if (past_end(first_source_start, wide_form ? 16'h0002 : 16'h0001)) begin
          bad_op   = 1'b1;
          bad_code = xchg_swap_pkg::ERR_RANGE;
        end
      end
      xchg_swap_pkg::OP_DIGIT_MOVE: begin
        if (digit_ops_bad) begin
          bad_op   = 1'b1;
          bad_code = xchg_swap_pkg::ERR_OPERAND;
        end else if (past_end(first_source_start, 16'h0001)
                     || past_end(second_source_start, 16'h0001)) begin
          bad_op   = 1'b1;
          bad_code = xchg_swap_pkg::ERR_RANGE;
        // Decimal range only matters with the format flag clear
        end else if (!number_format_flag && (src_w > xchg_swap_pkg::MAX_DECIMAL
                     || dst_w > xchg_swap_pkg::MAX_DECIMAL)) begin
          bad_op   = 1'b1;
          bad_code = xchg_swap_pkg::ERR_DECIMAL;
        end
      end
      // Code 3 is unassigned
      default: begin
        bad_op   = 1'b1;
        bad_code = xchg_swap_pkg::ERR_OPERAND;
      end
    endcase
  end

  // Exchange walker, one pair per cycle; overlapping blocks follow ascending order
  always_comb begin
    state_nxt = state_r;
    pa_nxt    = pa_r;
    pb_nxt    = pb_r;
    left_nxt  = left_r;
    unique case (state_r)
      xchg_swap_pkg::ST_IDLE: begin
        if (take && go_xchg) begin
          state_nxt = xchg_swap_pkg::ST_XCHG;
          pa_nxt    = first_source_start[ADDR_W-1:0];
          pb_nxt    = second_source_start[ADDR_W-1:0];
          left_nxt  = length;
        end
      end
      xchg_swap_pkg::ST_XCHG: begin
        pa_nxt   = pa_r + ADDR_W'(1);
        pb_nxt   = pb_r + ADDR_W'(1);
        left_nxt = left_r - 16'h0001;
        if (left_r == 16'h0001) begin
          state_nxt = xchg_swap_pkg::ST_IDLE;
        end
      end
    endcase
    // Next state decoded here so the port is a plain flop
    busy_nxt = (state_nxt == xchg_swap_pkg::ST_XCHG);
  end

  // Word store; loads only in idle so an operation sees a stable store
  always_comb begin
    mem_nxt = mem_r;
    if (state_r == xchg_swap_pkg::ST_XCHG) begin
      mem_nxt[pa_r] = mem_r[pb_r];
      mem_nxt[pb_r] = mem_r[pa_r];
    end else begin
      if (load_en) begin
        mem_nxt[load_addr] = load_data;
      end
      if (take && !bad_op && op == xchg_swap_pkg::OP_BYTE_SWAP) begin
        mem_nxt[first_source_start[ADDR_W-1:0]] = swap_bytes(src_w);
        // High word sits at the next device number
        if (wide_form) begin
          mem_nxt[hi_addr] = swap_bytes(mem_r[hi_addr]);
        end
      end
      // Source is only read, never written back
      if (take && !bad_op && op == xchg_swap_pkg::OP_DIGIT_MOVE) begin
        mem_nxt[second_source_start[ADDR_W-1:0]] =
          number_format_flag ? bin_res : dec_res;
      end
    end
  end

  // Status: done pulse, sticky error flag, last error code
  always_comb begin
    done_nxt = 1'b0;
    err_nxt  = err_r;
    code_nxt = code_r;
    if (clear_error) begin
      err_nxt = 1'b0;
    end
    if ((take && !go_xchg)
        || (state_r == xchg_swap_pkg::ST_XCHG && left_r == 16'h0001)) begin
      done_nxt = 1'b1;
    end
    // A new error outranks a clear in the same cycle
    if (take && bad_op) begin
      err_nxt  = 1'b1;
      code_nxt = bad_code;
    end
  end

  always_comb begin
    read_data_nxt = mem_r[read_addr];
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= xchg_swap_pkg::ST_IDLE;
      pa_r    <= '0;
      pb_r    <= '0;
      left_r  <= 16'h0000;
      busy_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pa_r    <= pa_nxt;
      pb_r    <= pb_nxt;
      left_r  <= left_nxt;
      busy_r  <= busy_nxt;
    end
  end

  // Every word clears on reset, at the cost of a wide reset fan-out
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= xchg_swap_pkg::MEM_RESET;
      end
    end else begin
      mem_r <= mem_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      done_r <= 1'b0;
      err_r  <= 1'b0;
      code_r <= xchg_swap_pkg::ERR_NONE;
    end else begin
      done_r <= done_nxt;
      err_r  <= err_nxt;
      code_r <= code_nxt;
    end
  end

  // Registered read, one edge behind the address
  always_ff @(posedge clk) begin
    if (reset) begin
      read_data_r <= xchg_swap_pkg::MEM_RESET;
    end else begin
      read_data_r <= read_data_nxt;
    end
  end

  assign read_data            = read_data_r;
  assign busy                 = busy_r;
  assign done                 = done_r;
  assign operation_error_flag = err_r;
  assign error_code_register  = code_r;

endmodule

// [core/xchg_swap_pkg.sv]
// Constants for the block exchange, byte swap and digit move datapath
package xchg_swap_pkg;
  localparam logic [1:0]  OP_BLOCK_XCHG  = 2'h0;
  localparam logic [1:0]  OP_BYTE_SWAP   = 2'h1;
  localparam logic [1:0]  OP_DIGIT_MOVE  = 2'h2;
  localparam logic [15:0] ERR_RANGE      = 16'h2003;
  localparam logic [15:0] ERR_OPERAND    = 16'h200B;
  localparam logic [15:0] ERR_DECIMAL    = 16'h200D;
  localparam logic [15:0] ERR_NONE       = 16'h0000;
  localparam logic [15:0] MAX_XCHG_LEN   = 16'h0100;
  localparam logic [15:0] MAX_DECIMAL    = 16'h270F;
  localparam logic [15:0] MEM_RESET      = 16'h0000;
  localparam logic [2:0]  DIGITS_PER_WORD = 3'h4;
  localparam int          DEPTH_DEFAULT  = 512;
  typedef enum logic {ST_IDLE, ST_XCHG} state_e;
endpackage

// [bench/op_checker.sv]
// Port-level timing and error-code checks for the datapath
`timescale 1ns/1ns
module op_checker (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        start,
  input wire logic [1:0]  op,
  input wire logic        wide_form,
  input wire logic        counter_operand,
  input wire logic        clear_error,
  input wire logic        busy,
  input wire logic        done,
  input wire logic [15:0] length,
  input wire logic [15:0] digit_count,
  input wire logic        operation_error_flag,
  input wire logic [15:0] error_code_register
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_take(logic [1:0] o);
    start && !busy && op == o;
  endsequence
  // Error outcome lands with the done pulse
  sequence s_err(logic [15:0] c);
    done && operation_error_flag && error_code_register == c;
  endsequence
  property p_xchg_run;
    s_take(2'h0) ##0 length == 16'h0002 |=> (busy [*2] ##1 (done && !busy)) or s_err(16'h2003);
  endproperty
  property p_xchg_len;
    s_take(2'h0) ##0 (length == 16'h0000 || length > 16'h0100) |=> s_err(16'h200B);
  endproperty
  property p_swap_narrow;
    s_take(2'h1) ##0 (counter_operand && !wide_form) |=> s_err(16'h2003);
  endproperty
  property p_swap_fast; s_take(2'h1) |=> done && !busy; endproperty
  property p_move_count; s_take(2'h2) ##0 digit_count == 16'h0000 |=> s_err(16'h200B); endproperty
  property p_move_fast; s_take(2'h2) |=> done; endproperty
  property p_code_cause; $changed(error_code_register) |-> done && operation_error_flag; endproperty
  property p_flag_hold; operation_error_flag && !clear_error |=> operation_error_flag; endproperty
  a_xchg_run: assert property (p_xchg_run) else $error("two-word exchange mistimed");
  a_xchg_len: assert property (p_xchg_len) else $error("bad length not refused");
  a_swap_narrow: assert property (p_swap_narrow) else $error("narrow counter swap taken");
  a_swap_fast: assert property (p_swap_fast) else $error("swap not done next cycle");
  a_move_count: assert property (p_move_count) else $error("zero count not refused");
  a_move_fast: assert property (p_move_fast) else $error("digit move not done");
  a_code_cause: assert property (p_code_cause) else $error("code changed without error");
  a_flag_hold: assert property (p_flag_hold) else $error("error flag dropped");
endmodule
bind xchg_swap_digit op_checker chk (.clk(clk), .reset(reset), .start(start), .op(op),
  .wide_form(wide_form), .counter_operand(counter_operand), .clear_error(clear_error),
  .busy(busy), .done(done), .length(length), .digit_count(digit_count),
  .operation_error_flag(operation_error_flag), .error_code_register(error_code_register));

// [bench/op_issuer.sv]
// Sequencer model: issues one operation, then waits for done
`timescale 1ns/1ns
module op_issuer (
  input  wire logic        clk,
  input  wire logic        done,
  output logic             start,
  output logic             wide,
  output logic             ctr,
  output logic             fmt,
  output logic [1:0]       op,
  output logic [15:0]      a,
  output logic [15:0]      b,
  output logic [15:0]      len,
  output logic [15:0]      m1,
  output logic [15:0]      m2,
  output logic [15:0]      dn
);
  initial {start, op, wide, ctr, fmt, a, b, len, m1, m2, dn} = '0;
  task automatic issue(input logic [1:0] o, input logic [2:0] f3, input logic [15:0] ia, ib,
                       il, input logic [11:0] dg);
    int k;
    @(negedge clk);
    {start, op, wide, ctr, fmt} = {1'b1, o, f3};
    {a, b, len} = {ia, ib, il};
    {m1, m2, dn} = {12'h0, dg[11:8], 12'h0, dg[7:4], 12'h0, dg[3:0]};
    @(negedge clk);
    start = 1'b0;
    // Operands are only valid at the take edge, so scramble them afterwards
    {a, b, len, m1, m2, dn} = ~{a, b, len, m1, m2, dn};
    k = 0;
    while (done !== 1'b1 && k < 400) begin
      @(negedge clk);
      k++;
    end
  endtask
endmodule

// [bench/tb.sv]
// Self-checking bench for the exchange, swap and digit move datapath
`timescale 1ns/1ns
module tb;
  localparam int D = 64;
  logic        clk = 1'b0, reset = 1'b1, clear_error = 1'b0, load_en = 1'b0, ef = 1'b0;
  logic [5:0]  load_addr = '0, read_addr = '0;
  logic [15:0] load_data = '0, rnd = 16'h0026, ec = '0, read_data, error_code_register;
  logic        start, wide, ctr, fmt, busy, done, operation_error_flag;
  logic [1:0]  op;
  logic [15:0] a, b, len, m1, m2, dn;
  logic [15:0] sh [D];
  logic [16:0] expq [$];
  logic [16:0] e;
  logic [11:0] bad [6] = '{12'h011, 12'h514, 12'h233, 12'h421, 12'h425, 12'h401};
  int          err_count = 0, n_tests = 0, cyc = 0, x, y, z;
  always #4 clk = ~clk;
  xchg_swap_digit #(.DEPTH(D)) dut (.clk(clk), .reset(reset), .start(start), .op(op),
    .wide_form(wide), .counter_operand(ctr), .number_format_flag(fmt),
    .first_source_start(a), .second_source_start(b), .length(len),
    .source_start_digit(m1), .digit_count(m2), .dest_start_digit(dn),
    .clear_error(clear_error), .load_en(load_en), .load_addr(load_addr),
    .load_data(load_data), .read_addr(read_addr), .read_data(read_data), .busy(busy),
    .done(done), .operation_error_flag(operation_error_flag),
    .error_code_register(error_code_register));
  op_issuer iss (.clk(clk), .done(done), .start(start), .wide(wide), .ctr(ctr), .fmt(fmt),
    .op(op), .a(a), .b(b), .len(len), .m1(m1), .m2(m2), .dn(dn));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Digits are taken in base 10 or 16, so one model serves both formats
  function automatic logic [15:0] mv(input int s, d, p, c, n, input bit dec);
    int bs, r;
    int sd [4];
    int dd [4];
    bs = dec ? 10 : 16;
    r = 0;
    for (int i = 0; i < 4; i++) begin
      sd[i] = (s / bs ** i) % bs;
      dd[i] = (d / bs ** i) % bs;
    end
    for (int i = 0; i < c; i++) dd[n - 1 - i] = sd[p - 1 - i];
    for (int i = 3; i >= 0; i--) r = r * bs + dd[i];
    return r[15:0];
  endfunction
  task automatic check(input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (err_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic load(input logic [5:0] ad, input logic [15:0] d);
    @(negedge clk);
    {load_en, load_addr, load_data} = {1'b1, ad, d};
    sh[ad] = d;
    @(negedge clk);
    load_en = 1'b0;
  endtask
  task automatic run(input logic [1:0] o, input logic [2:0] f3, input logic [15:0] ra, rb,
                     rl, input logic [11:0] dg, input logic [15:0] c);
    logic [15:0] t;
    if (c !== 16'h0000) begin
      ef = 1'b1;
      ec = c;
    end else if (o == 2'h0) begin
      for (int i = 0; i < rl; i++) begin
        t = sh[ra + i];
        sh[ra + i] = sh[rb + i];
        sh[rb + i] = t;
      end
    end else if (o == 2'h1) begin
      for (int i = 0; i <= f3[2]; i++) sh[ra + i] = {sh[ra + i][7:0], sh[ra + i][15:8]};
    end else sh[rb] = mv(sh[ra], sh[rb], dg[11:8], dg[7:4], dg[3:0], !f3[0]);
    expq.push_back({ef, ec});
    iss.issue(o, f3, ra, rb, rl, dg);
  endtask
  always @(negedge clk) if (done === 1'b1 && !reset) begin
    e = (expq.size() > 0) ? expq.pop_front() : 17'h1FFFF;
    check({15'h0, operation_error_flag}, {15'h0, e[16]});
    check(error_code_register, e[15:0]);
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      err_count++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk) reset = 1'b0;
    for (int i = 0; i < D; i++) begin
      rnd = lfsr(rnd);
      load(i[5:0], rnd);
    end
    load(6'h14, 16'h04D2);
    load(6'h15, 16'h162E);
    load(6'h16, 16'h1234);
    load(6'h17, 16'h5678);
    load(6'h18, 16'h2710);
    run(2'h0, 3'h0, 16'hA, 16'h28, 16'h2, 12'h0, 16'h0);
    run(2'h0, 3'h0, 16'h3F, 16'h0, 16'h1, 12'h0, 16'h0);
    run(2'h0, 3'h0, 16'h0, 16'h1, 16'h100, 12'h0, 16'h2003);
    run(2'h0, 3'h0, 16'h5, 16'h3C, 16'h5, 12'h0, 16'h2003);
    run(2'h0, 3'h0, 16'h5, 16'h6, 16'h0, 12'h0, 16'h200B);
    run(2'h0, 3'h0, 16'h5, 16'h6, 16'h101, 12'h0, 16'h200B);
    run(2'h1, 3'h0, 16'h3, 16'h0, 16'h0, 12'h0, 16'h0);
    run(2'h1, 3'h4, 16'h6, 16'h0, 16'h0, 12'h0, 16'h0);
    run(2'h1, 3'h6, 16'h8, 16'h0, 16'h0, 12'h0, 16'h0);
    run(2'h1, 3'h2, 16'h8, 16'h0, 16'h0, 12'h0, 16'h2003);
    run(2'h2, 3'h0, 16'h14, 16'h15, 16'h0, 12'h423, 16'h0);
    run(2'h2, 3'h1, 16'h16, 16'h17, 16'h0, 12'h423, 16'h0);
    run(2'h2, 3'h0, 16'h18, 16'h15, 16'h0, 12'h423, 16'h200D);
    run(2'h2, 3'h0, 16'h15, 16'h18, 16'h0, 12'h423, 16'h200D);
    for (int i = 0; i < 6; i++) run(2'h2, 3'h1, 16'h1E, 16'h1F, 16'h0, bad[i], 16'h200B);
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      x = 1 + rnd % 4;
      y = 1 + (rnd >> 4) % x;
      z = y + (rnd >> 8) % (5 - y);
      run(2'h2, 3'h1, 16'h1E, 16'h1F, 16'h0, {x[3:0], y[3:0], z[3:0]}, 16'h0);
    end
    run(2'h3, 3'h0, 16'h0, 16'h0, 16'h0, 12'h0, 16'h200B);
    @(negedge clk) clear_error = 1'b1;
    @(negedge clk) clear_error = 1'b0;
    ef = 1'b0;
    check({15'h0, operation_error_flag}, 16'h0);
    run(2'h1, 3'h0, 16'h3, 16'h0, 16'h0, 12'h0, 16'h0);
    for (int i = 0; i < D; i++) begin
      @(negedge clk) read_addr = i[5:0];
      @(negedge clk) check(read_data, sh[i]);
    end
    check(16'(expq.size()), 16'h0000);
    tally_and_finish();
  end
endmodule
